// ---- hdl/fsc_pkg.sv ----
package fsc_pkg;

  // Fuse values as delivered; a programmed fuse reads 0
  localparam logic [7:0] FSC_EXT_RESET       = 8'hff;
  localparam logic [7:0] FSC_HIGH_RESET      = 8'h99;
  localparam logic [7:0] FSC_LOW_RESET       = 8'h62;
  localparam logic [7:0] FSC_EXT_STUCK_MASK  = 8'hf8;
  localparam logic [7:0] FSC_NO_MASK         = 8'h00;
  localparam logic [7:0] FSC_SERIAL_GUARD    = 8'h20;

  // Parallel command bytes
  localparam logic [7:0] FSC_CMD_CHIP_ERASE  = 8'h80;
  localparam logic [7:0] FSC_CMD_WRITE_FUSE  = 8'h40;
  localparam logic [7:0] FSC_CMD_READ_SIG    = 8'h08;
  localparam logic [7:0] FSC_CMD_READ_FUSE   = 8'h04;
  localparam logic [7:0] FSC_CMD_RESET       = 8'h00;

  // Strobe actions on the rising clock-pin edge
  localparam logic [1:0] FSC_ACT_ADDR        = 2'h0;
  localparam logic [1:0] FSC_ACT_DATA        = 2'h1;
  localparam logic [1:0] FSC_ACT_CMD         = 2'h2;

  // Byte select {sel2, sel1}
  localparam logic [1:0] FSC_SEL_LOW         = 2'h0;
  localparam logic [1:0] FSC_SEL_HIGH_LOCK   = 2'h1;
  localparam logic [1:0] FSC_SEL_EXT         = 2'h2;
  localparam logic [1:0] FSC_SEL_HIGH_READ   = 2'h3;

  // Signature space offsets
  localparam logic [7:0] FSC_SIG_OFFSET_0    = 8'h00;
  localparam logic [7:0] FSC_SIG_OFFSET_1    = 8'h01;
  localparam logic [7:0] FSC_SIG_OFFSET_2    = 8'h02;

  // Timing at 25 MHz
  localparam int unsigned FSC_CLK_PERIOD_NS   = 40;
  localparam int unsigned FSC_PULSE_MIN_NS    = 250;
  localparam int unsigned FSC_PULSE_MIN_CYCLES =
    (FSC_PULSE_MIN_NS + FSC_CLK_PERIOD_NS - 1) / FSC_CLK_PERIOD_NS;
  localparam logic [2:0] FSC_WRITE_BUSY_CYCLES = 3'h4;

  // Page geometry
  localparam int unsigned FSC_FLASH_PAGE_WORDS_SMALL = 64;
  localparam int unsigned FSC_FLASH_PAGE_WORDS_LARGE = 128;
  localparam int unsigned FSC_FLASH_WORD_BITS        = $clog2(FSC_FLASH_PAGE_WORDS_LARGE);
  localparam int unsigned FSC_EE_PAGE_BYTES_SMALL    = 4;
  localparam int unsigned FSC_EE_PAGE_BYTES_LARGE    = 8;
  localparam int unsigned FSC_EE_BYTE_BITS           = $clog2(FSC_EE_PAGE_BYTES_LARGE);
  localparam int unsigned FSC_FLASH_PAGE_BITS        = 8;

  typedef struct packed {
    logic [4:0] unused;
    logic       brownout_level_sel_2;
    logic       brownout_level_sel_1;
    logic       brownout_level_sel_0;
  } fsc_ext_t;

  typedef struct packed {
    logic onchip_debug_enable_fuse;
    logic boundary_scan_enable_fuse;
    logic serial_download_enable_fuse;
    logic watchdog_force_on_fuse;
    logic eeprom_preserve_fuse;
    logic boot_size_sel_1;
    logic boot_size_sel_0;
    logic reset_vector_sel_fuse;
  } fsc_high_t;

  typedef struct packed {
    logic clock_div_eight_fuse;
    logic clock_output_fuse;
    logic startup_time_sel_1;
    logic startup_time_sel_0;
    logic clock_source_sel_3;
    logic clock_source_sel_2;
    logic clock_source_sel_1;
    logic clock_source_sel_0;
  } fsc_low_t;

  typedef enum logic [1:0] {
    FSC_MODE_NORMAL = 2'b00,
    FSC_MODE_PROG   = 2'b01,
    FSC_MODE_BUSY   = 2'b10
  } fsc_mode_t;

  typedef struct packed {
    logic [7:0] value;
  } fsc_cell_st_t;

endpackage : fsc_pkg

// ---- hdl/fsc_fuse_cell.sv ----
`timescale 1ns/100ps
`default_nettype none
module fsc_fuse_cell #(
  parameter logic [7:0] RESET_VALUE = 8'hff,
  parameter logic [7:0] STUCK_MASK  = 8'h00,
  parameter logic [7:0] GUARD_MASK  = 8'h00
) (
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire logic       writeEn,
  input  wire logic       guardOn,
  input  wire logic [7:0] writeData,
  output logic      [7:0] fuseValue
);
  import fsc_pkg::*;

  fsc_cell_st_t st;
  fsc_cell_st_t next_st;
  logic [7:0]   keepMask;

  always_comb begin
    keepMask = guardOn ? GUARD_MASK : 8'h00;
    next_st  = st;
    if (writeEn) begin
      // Unused bits always read back unprogrammed
      next_st.value = (writeData & ~keepMask) | (st.value & keepMask) | STUCK_MASK;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      st.value <= RESET_VALUE | STUCK_MASK;
    end else begin
      st <= next_st;
    end
  end

  assign fuseValue = st.value;

endmodule : fsc_fuse_cell
`default_nettype wire

// ---- hdl/fsc_fuse_store.sv ----
`timescale 1ns/100ps
`default_nettype none
module fsc_fuse_store #(
  parameter logic [7:0] SIG_BYTE_ZERO = 8'h5a,  // Arbitrary identity value
  parameter logic [7:0] SIG_BYTE_ONE  = 8'h3c,  // Arbitrary identity value
  parameter logic [7:0] SIG_BYTE_TWO  = 8'h71,  // Arbitrary identity value
  parameter logic [7:0] CAL_VALUE     = 8'h80   // Arbitrary factory trim
) (
  input  wire logic                      ref_clk,
  input  wire logic                      rst_n,
  input  wire logic                      progMode,
  input  wire logic                      progSerial,
  input  wire logic                      xtal1,
  input  wire logic [1:0]                xtalAction,
  input  wire logic                      byteSel1,
  input  wire logic                      byteSel2,
  input  wire logic                      wrN,
  input  wire logic                      oeN,
  input  wire logic [7:0]                dataIn,
  input  wire logic [7:0]                lockByte,
  output logic      [7:0]                dataOut,
  output logic                           dataOe,
  output logic                           readyBusy,
  output fsc_pkg::fsc_ext_t              extShadow,
  output fsc_pkg::fsc_high_t             highShadow,
  output fsc_pkg::fsc_low_t              lowShadow,
  output logic                           eepromPreserve,
  output logic                           sleepClockKeep,
  output logic                           portBBitOneClkSel,
  output logic      [7:0]                oscillatorTuningRegister,
  output logic      [6:0]                pageWordIndex,
  output logic      [7:0]                pageNumberIndex,
  output logic      [2:0]                eeByteIndex
);
  import fsc_pkg::*;

  typedef struct packed {
    fsc_mode_t  mode;
    logic       started;
    logic       progPrev;
    logic       xtalPrev;
    logic       wrPrev;
    logic       oePrev;
    logic [7:0] cmd;
    logic [7:0] addrLow;
    logic [7:0] addrHigh;
    logic [7:0] dataLatch;
    logic [2:0] busyCnt;
    logic       rdy;
    logic [7:0] dout;
    logic       doe;
    fsc_ext_t   extSh;
    fsc_high_t  highSh;
    fsc_low_t   lowSh;
    logic       eePres;
    logic       sleepKeep;
    logic       clkOutSel;
    logic [7:0] tune;
    logic [6:0] pageWord;
    logic [7:0] pageNum;
    logic [2:0] eeByte;
  } fsc_state_t;

  fsc_state_t st;
  fsc_state_t next_st;

  logic [7:0] nvExt;
  logic [7:0] nvHigh;
  logic [7:0] nvLow;
  logic       xtalRise;
  logic       wrFall;
  logic       wrFuse;
  logic       fuseWriteOk;
  logic       latchNow;
  logic [1:0] byteSel;
  logic [7:0] readByte;
  logic [15:0] fullAddr;

  ////////////////////////////////////////////////////////////////////////////
  // Non-volatile fuse bytes

  fsc_fuse_cell #(
    .RESET_VALUE (FSC_EXT_RESET),
    .STUCK_MASK  (FSC_EXT_STUCK_MASK),
    .GUARD_MASK  (FSC_NO_MASK)
  ) u_ext_cell (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .writeEn   (wrFuse && byteSel == FSC_SEL_EXT),
    .guardOn   (progSerial),
    .writeData (st.dataLatch),
    .fuseValue (nvExt)
  );

  fsc_fuse_cell #(
    .RESET_VALUE (FSC_HIGH_RESET),
    .STUCK_MASK  (FSC_NO_MASK),
    .GUARD_MASK  (FSC_SERIAL_GUARD)
  ) u_high_cell (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .writeEn   (wrFuse && byteSel == FSC_SEL_HIGH_LOCK),
    .guardOn   (progSerial),
    .writeData (st.dataLatch),
    .fuseValue (nvHigh)
  );

  fsc_fuse_cell #(
    .RESET_VALUE (FSC_LOW_RESET),
    .STUCK_MASK  (FSC_NO_MASK),
    .GUARD_MASK  (FSC_NO_MASK)
  ) u_low_cell (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .writeEn   (wrFuse && byteSel == FSC_SEL_LOW),
    .guardOn   (progSerial),
    .writeData (st.dataLatch),
    .fuseValue (nvLow)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Programming port decode
  // Strobes are sampled once per clock; pulses shorter than a clock may be
  // missed, which the minimum pulse width of the programmer rules out.

  always_comb begin
    byteSel     = {byteSel2, byteSel1};
    xtalRise    = progMode && xtal1 && !st.xtalPrev;
    wrFall      = progMode && !wrN && st.wrPrev;
    fuseWriteOk = lockByte[0];
    wrFuse      = wrFall && st.mode == FSC_MODE_PROG && st.cmd == FSC_CMD_WRITE_FUSE
                  && fuseWriteOk;
    latchNow    = (!st.started && !progMode)
                  || (st.started && progMode != st.progPrev);
    fullAddr    = {st.addrHigh, st.addrLow};
    readByte    = 8'hff;
    unique case (st.cmd)
      FSC_CMD_READ_FUSE: begin
        unique case (byteSel)
          FSC_SEL_LOW:       readByte = nvLow;
          FSC_SEL_HIGH_LOCK: readByte = lockByte;
          FSC_SEL_EXT:       readByte = nvExt;
          FSC_SEL_HIGH_READ: readByte = nvHigh;
        endcase
      end
      FSC_CMD_READ_SIG: begin
        if (byteSel1) begin
          readByte = CAL_VALUE;
        end else begin
          unique case (st.addrLow)
            FSC_SIG_OFFSET_0: readByte = SIG_BYTE_ZERO;
            FSC_SIG_OFFSET_1: readByte = SIG_BYTE_ONE;
            FSC_SIG_OFFSET_2: readByte = SIG_BYTE_TWO;
            default:          readByte = 8'hff;
          endcase
        end
      end
      default: readByte = 8'hff;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // State update

  always_comb begin
    next_st          = st;
    next_st.started  = 1'b1;
    next_st.progPrev = progMode;
    next_st.xtalPrev = xtal1;
    next_st.wrPrev   = wrN;
    next_st.oePrev   = oeN;

    unique case (st.mode)
      FSC_MODE_NORMAL: begin
        if (progMode) begin
          next_st.mode = FSC_MODE_PROG;
          next_st.cmd  = FSC_CMD_RESET;
        end
      end
      FSC_MODE_PROG: begin
        if (!progMode) begin
          next_st.mode = FSC_MODE_NORMAL;
        end else if (wrFall) begin
          // Every write command, erase included, shows busy; fuses stay
          next_st.mode    = FSC_MODE_BUSY;
          next_st.busyCnt = FSC_WRITE_BUSY_CYCLES;
        end
      end
      FSC_MODE_BUSY: begin
        next_st.busyCnt = st.busyCnt - 3'h1;
        if (st.busyCnt == 3'h1) begin
          next_st.mode = progMode ? FSC_MODE_PROG : FSC_MODE_NORMAL;
        end
      end
      default: next_st.mode = FSC_MODE_NORMAL;
    endcase

    // Loads are refused while busy so a write keeps its data
    if (xtalRise && st.mode == FSC_MODE_PROG) begin
      unique case (xtalAction)
        FSC_ACT_ADDR: begin
          if (byteSel == FSC_SEL_LOW) begin
            next_st.addrLow = dataIn;
          end else if (byteSel == FSC_SEL_HIGH_LOCK) begin
            next_st.addrHigh = dataIn;
          end
        end
        FSC_ACT_DATA: next_st.dataLatch = dataIn;
        FSC_ACT_CMD:  next_st.cmd = dataIn;
        default: ;
      endcase
    end

    next_st.rdy  = (next_st.mode != FSC_MODE_BUSY);
    next_st.doe  = progMode && !oeN && st.mode == FSC_MODE_PROG
                   && (st.cmd == FSC_CMD_READ_FUSE || st.cmd == FSC_CMD_READ_SIG);
    next_st.dout = next_st.doe ? readByte : 8'h00;

    // Shadows move only at latch events, except eePres, which also follows nvHigh[3] throughout programming mode
    if (latchNow) begin
      next_st.extSh     = fsc_ext_t'(nvExt);
      next_st.highSh    = fsc_high_t'(nvHigh);
      next_st.lowSh     = fsc_low_t'(nvLow);
      next_st.eePres    = !nvHigh[3];
      next_st.sleepKeep = !nvHigh[7];
      next_st.clkOutSel = !nvLow[6];
    end
    if (progMode) begin
      next_st.eePres = !nvHigh[3];
    end

    next_st.pageWord = fullAddr[FSC_FLASH_WORD_BITS-1:0];
    next_st.pageNum  = fullAddr[FSC_FLASH_WORD_BITS +: FSC_FLASH_PAGE_BITS];
    next_st.eeByte   = fullAddr[FSC_EE_BYTE_BITS-1:0];
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      st           <= '0;
      st.mode      <= FSC_MODE_NORMAL;
      st.progPrev  <= 1'b0;
      st.xtalPrev  <= 1'b0;
      st.wrPrev    <= 1'b1;
      st.oePrev    <= 1'b1;
      st.rdy       <= 1'b1;
      st.extSh     <= fsc_ext_t'(FSC_EXT_RESET | FSC_EXT_STUCK_MASK);
      st.highSh    <= fsc_high_t'(FSC_HIGH_RESET);
      st.lowSh     <= fsc_low_t'(FSC_LOW_RESET);
      st.tune      <= CAL_VALUE;
    end else begin
      st <= next_st;
    end
  end

  assign dataOut                  = st.dout;
  assign dataOe                   = st.doe;
  assign readyBusy                = st.rdy;
  assign extShadow                = st.extSh;
  assign highShadow               = st.highSh;
  assign lowShadow                = st.lowSh;
  assign eepromPreserve           = st.eePres;
  assign sleepClockKeep           = st.sleepKeep;
  assign portBBitOneClkSel        = st.clkOutSel;
  assign oscillatorTuningRegister = st.tune;
  assign pageWordIndex            = st.pageWord;
  assign pageNumberIndex          = st.pageNum;
  assign eeByteIndex              = st.eeByte;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking dc @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence busyWindow;
    !readyBusy [*4] ##1 readyBusy;
  endsequence

  sequence writeTaken;
    wrFall && st.mode == FSC_MODE_PROG;
  endsequence

  write_busy_a: assert property (writeTaken |=> busyWindow)
    else $error("ready line not low for four cycles after write");

  fuse_lock_a: assert property (
    wrFall && !lockByte[0] |=> $stable({nvExt, nvHigh, nvLow}))
    else $error("fuse changed while lock bit one programmed");

  erase_keep_a: assert property (
    wrFall && st.cmd != FSC_CMD_WRITE_FUSE |=> $stable({nvExt, nvHigh, nvLow}))
    else $error("fuse changed by a non fuse command");

  serial_guard_a: assert property (
    progSerial |=> nvHigh[5] == $past(nvHigh[5]))
    else $error("serial download fuse changed in serial mode");

  shadow_hold_a: assert property (
    st.started && progMode && st.progPrev
      |=> $stable({extShadow, highShadow, lowShadow, portBBitOneClkSel}))
    else $error("shadow changed inside programming mode");

  ee_follow_a: assert property (
    progMode |=> eepromPreserve == !$past(nvHigh[3]))
    else $error("preserve fuse not applied at once");

  power_latch_a: assert property (
    $rose(st.started) && !$past(progMode)
      |-> lowShadow == fsc_low_t'($past(nvLow)) && sleepClockKeep == !highShadow[7])
    else $error("fuses not latched at power-up");

  fuse_read_a: assert property (
    progMode && !oeN && st.mode == FSC_MODE_PROG && st.cmd == FSC_CMD_READ_FUSE
      && byteSel == FSC_SEL_EXT |=> dataOe && dataOut == $past(nvExt))
    else $error("extended fuse read back wrong");

  sig_read_a: assert property (
    progMode && !oeN && st.mode == FSC_MODE_PROG && st.cmd == FSC_CMD_READ_SIG
      && !byteSel1 && st.addrLow == FSC_SIG_OFFSET_1 |=> dataOut == SIG_BYTE_ONE)
    else $error("signature byte one read back wrong");

  tune_reset_a: assert property (@(posedge ref_clk) disable iff (1'b0)
    !rst_n |=> oscillatorTuningRegister == CAL_VALUE)
    else $error("tuning register not loaded in reset");

endmodule : fsc_fuse_store
`default_nettype wire

// ---- verif/fsc_prog_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module fsc_prog_model (
  input  wire logic       ref_clk,
  input  wire logic [7:0] dataOut,
  input  wire logic       dataOe,
  input  wire logic       readyBusy,
  output logic            progMode,
  output logic            progSerial,
  output logic            xtal1,
  output logic      [1:0] xtalAction,
  output logic            byteSel1,
  output logic            byteSel2,
  output logic            wrN,
  output logic            oeN,
  output logic      [7:0] dataIn,
  output logic      [7:0] lockByte
);
  import fsc_pkg::*;

  initial begin
    progMode   = 1'b0;
    progSerial = 1'b0;
    xtal1      = 1'b0;
    xtalAction = 2'h3;
    byteSel1   = 1'b0;
    byteSel2   = 1'b0;
    wrN        = 1'b1;
    oeN        = 1'b1;
    dataIn     = 8'h00;
    lockByte   = 8'hff;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic set_mode(input logic pm, input logic ser, input logic [7:0] lk);
    @(posedge ref_clk);
    progMode   <= pm;
    progSerial <= ser;
    lockByte   <= lk;
    repeat (4) @(posedge ref_clk);
  endtask : set_mode

  // Released data bus shows the inverse of the last byte, never a stale copy
  task automatic strobe(input logic [1:0] act, input logic [7:0] d, input logic [1:0] sel);
    @(posedge ref_clk);
    xtalAction           <= act;
    dataIn               <= d;
    {byteSel2, byteSel1} <= sel;
    xtal1                <= 1'b1;
    repeat (FSC_PULSE_MIN_CYCLES) @(posedge ref_clk);
    xtal1                <= 1'b0;
    repeat (FSC_PULSE_MIN_CYCLES) @(posedge ref_clk);
    xtalAction           <= 2'h3;
    dataIn               <= ~d;
  endtask : strobe

  task automatic write_pulse(output int busy);
    busy = 0;
    @(posedge ref_clk);
    wrN <= 1'b0;
    repeat (FSC_PULSE_MIN_CYCLES) begin
      @(posedge ref_clk);
      if (readyBusy === 1'b0) busy++;
    end
    wrN <= 1'b1;
    repeat (FSC_PULSE_MIN_CYCLES) @(posedge ref_clk);
  endtask : write_pulse

  task automatic read_byte(input logic [1:0] sel, output logic [7:0] d, output logic oe);
    @(posedge ref_clk);
    {byteSel2, byteSel1} <= sel;
    oeN                  <= 1'b0;
    repeat (FSC_PULSE_MIN_CYCLES) @(posedge ref_clk);
    d   = dataOut;
    oe  = dataOe;
    oeN <= 1'b1;
    repeat (3) @(posedge ref_clk);
  endtask : read_byte
endmodule : fsc_prog_model
`default_nettype wire

// ---- verif/tb.sv ----
`timescale 1ns/100ps
`default_nettype none
`define CHK(NAME, EXP, GOT) \
  begin \
    compares++; \
    if ((GOT) !== (EXP)) begin \
      fails++; \
      $display("MISMATCH %s expected %h seen %h", NAME, EXP, GOT); \
    end \
  end
module tb;
  import fsc_pkg::*;
  localparam logic [7:0] SIG0 = 8'h21;  // Arbitrary identity value
  localparam logic [7:0] SIG1 = 8'h43;  // Arbitrary identity value
  localparam logic [7:0] SIG2 = 8'h65;  // Arbitrary identity value
  localparam logic [7:0] CAL  = 8'h97;  // Arbitrary trim value

  logic       ref_clk = 1'b0;
  logic       rst_n   = 1'b0;
  logic       progMode, progSerial, xtal1, byteSel1, byteSel2, wrN, oeN;
  logic [1:0] xtalAction;
  logic [7:0] dataIn, lockByte, dataOut, tuning;
  logic       dataOe, readyBusy, eepromPreserve, sleepClockKeep, portBBitOneClkSel;
  fsc_ext_t   extShadow;
  fsc_high_t  highShadow;
  fsc_low_t   lowShadow;
  logic [6:0] pageWordIndex;
  logic [7:0] pageNumberIndex;
  logic [2:0] eeByteIndex;
  int         fails    = 0;
  int         compares = 0;

  always #20 ref_clk = ~ref_clk;

  fsc_fuse_store #(.SIG_BYTE_ZERO(SIG0), .SIG_BYTE_ONE(SIG1), .SIG_BYTE_TWO(SIG2),
                   .CAL_VALUE(CAL)) u_dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .progMode(progMode), .progSerial(progSerial),
    .xtal1(xtal1), .xtalAction(xtalAction), .byteSel1(byteSel1), .byteSel2(byteSel2),
    .wrN(wrN), .oeN(oeN), .dataIn(dataIn), .lockByte(lockByte), .dataOut(dataOut),
    .dataOe(dataOe), .readyBusy(readyBusy), .extShadow(extShadow),
    .highShadow(highShadow), .lowShadow(lowShadow), .eepromPreserve(eepromPreserve),
    .sleepClockKeep(sleepClockKeep), .portBBitOneClkSel(portBBitOneClkSel),
    .oscillatorTuningRegister(tuning), .pageWordIndex(pageWordIndex),
    .pageNumberIndex(pageNumberIndex), .eeByteIndex(eeByteIndex));

  fsc_prog_model u_prog (
    .ref_clk(ref_clk), .dataOut(dataOut), .dataOe(dataOe), .readyBusy(readyBusy),
    .progMode(progMode), .progSerial(progSerial), .xtal1(xtal1), .xtalAction(xtalAction),
    .byteSel1(byteSel1), .byteSel2(byteSel2), .wrN(wrN), .oeN(oeN), .dataIn(dataIn),
    .lockByte(lockByte));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : close_out

  task automatic check_defaults();
    `CHK("extShadow", FSC_EXT_RESET, extShadow)
    `CHK("highShadow", FSC_HIGH_RESET, highShadow)
    `CHK("lowShadow", FSC_LOW_RESET, lowShadow)
    `CHK("sleepClockKeep", 1'b0, sleepClockKeep)
    `CHK("portBBitOneClkSel", 1'b0, portBBitOneClkSel)
    `CHK("eepromPreserve", 1'b0, eepromPreserve)
    `CHK("tuning", CAL, tuning)
    `CHK("readyBusy", 1'b1, readyBusy)
  endtask : check_defaults

  task automatic fuse_write(input logic [1:0] sel, input logic [7:0] v);
    int busy;
    u_prog.strobe(FSC_ACT_CMD, FSC_CMD_WRITE_FUSE, FSC_SEL_LOW);
    u_prog.strobe(FSC_ACT_DATA, v, sel);
    u_prog.write_pulse(busy);
    `CHK("busyCycles", FSC_WRITE_BUSY_CYCLES, busy)
  endtask : fuse_write

  // Erase must really run: a write pulse under the erase command
  task automatic chip_erase();
    int busy;
    u_prog.strobe(FSC_ACT_CMD, FSC_CMD_CHIP_ERASE, FSC_SEL_LOW);
    u_prog.write_pulse(busy);
    `CHK("eraseBusy", FSC_WRITE_BUSY_CYCLES, busy)
  endtask : chip_erase

  task automatic fuse_read(input logic [1:0] sel, input logic [7:0] exp);
    logic [7:0] d;
    logic       oe;
    u_prog.strobe(FSC_ACT_CMD, FSC_CMD_READ_FUSE, FSC_SEL_LOW);
    u_prog.read_byte(sel, d, oe);
    `CHK("fuseByte", exp, d)
    `CHK("dataOe", 1'b1, oe)
  endtask : fuse_read

  task automatic sig_read(input logic [7:0] addr, input logic [1:0] sel,
                          input logic [7:0] exp);
    logic [7:0] d;
    logic       oe;
    u_prog.strobe(FSC_ACT_CMD, FSC_CMD_READ_SIG, FSC_SEL_LOW);
    u_prog.strobe(FSC_ACT_ADDR, addr, FSC_SEL_LOW);
    u_prog.read_byte(sel, d, oe);
    `CHK("sigByte", exp, d)
  endtask : sig_read

  task automatic all_sig();
    sig_read(FSC_SIG_OFFSET_0, FSC_SEL_LOW, SIG0);
    sig_read(FSC_SIG_OFFSET_1, FSC_SEL_LOW, SIG1);
    sig_read(FSC_SIG_OFFSET_2, FSC_SEL_LOW, SIG2);
    sig_read(FSC_SIG_OFFSET_0, FSC_SEL_HIGH_LOCK, CAL);
    sig_read(8'h03, FSC_SEL_LOW, 8'hff);
  endtask : all_sig

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    check_defaults();
    $display("test defaults done");
    u_prog.set_mode(1'b1, 1'b0, 8'hff);
    fuse_read(FSC_SEL_LOW, FSC_LOW_RESET);
    fuse_read(FSC_SEL_HIGH_LOCK, 8'hff);
    fuse_read(FSC_SEL_EXT, FSC_EXT_RESET);
    fuse_read(FSC_SEL_HIGH_READ, FSC_HIGH_RESET);
    all_sig();
    $display("test reads done");
    // Fuses go in before any lock bit is programmed
    fuse_write(FSC_SEL_LOW, 8'h22);
    fuse_write(FSC_SEL_HIGH_LOCK, 8'h11);
    `CHK("eepromPreserve", 1'b1, eepromPreserve)
    `CHK("highShadow", FSC_HIGH_RESET, highShadow)
    `CHK("lowShadow", FSC_LOW_RESET, lowShadow)
    `CHK("sleepClockKeep", 1'b0, sleepClockKeep)
    fuse_write(FSC_SEL_EXT, 8'h00);
    fuse_read(FSC_SEL_EXT, FSC_EXT_STUCK_MASK);
    chip_erase();
    fuse_read(FSC_SEL_LOW, 8'h22);
    fuse_write(FSC_SEL_LOW, 8'h22);
    chip_erase();
    fuse_read(FSC_SEL_HIGH_READ, 8'h11);
    $display("test writes done");
    u_prog.strobe(FSC_ACT_ADDR, 8'ha5, FSC_SEL_LOW);
    u_prog.strobe(FSC_ACT_ADDR, 8'h3c, FSC_SEL_HIGH_LOCK);
    `CHK("pageWordIndex", 7'h25, pageWordIndex)
    `CHK("pageNumberIndex", 8'h79, pageNumberIndex)
    `CHK("eeByteIndex", 3'h5, eeByteIndex)
    $display("test paging done");
    u_prog.set_mode(1'b0, 1'b0, 8'hff);
    `CHK("lowShadow", 8'h22, lowShadow)
    `CHK("highShadow", 8'h11, highShadow)
    `CHK("extShadow", FSC_EXT_STUCK_MASK, extShadow)
    `CHK("portBBitOneClkSel", 1'b1, portBBitOneClkSel)
    `CHK("sleepClockKeep", 1'b1, sleepClockKeep)
    `CHK("eepromPreserve", 1'b1, eepromPreserve)
    $display("test exit latch done");
    u_prog.set_mode(1'b1, 1'b0, 8'hfe);
    fuse_write(FSC_SEL_LOW, 8'h00);
    fuse_read(FSC_SEL_LOW, 8'h22);
    all_sig();
    $display("test lock done");
    u_prog.set_mode(1'b1, 1'b1, 8'hff);
    fuse_write(FSC_SEL_HIGH_LOCK, 8'hff);
    fuse_read(FSC_SEL_HIGH_READ, 8'hdf);
    $display("test serial guard done");
    u_prog.set_mode(1'b0, 1'b0, 8'hff);
    @(posedge ref_clk);
    rst_n <= 1'b0;
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    check_defaults();
    $display("test second reset done");
    close_out();
  end

  // Whole sequence needs roughly 1050 cycles
  initial begin
    #(40 * 20000);
    fails++;
    close_out();
  end
endmodule : tb
`default_nettype wire
